/* File: common/slcb_pkg.sv */
// Package: register map, field positions, reset values and timing counts of the synth bank
package slcb_pkg;

  localparam int SLCB_ADDR_W = 15;
  localparam int SLCB_NREG = 16;

  // Register offsets
  localparam logic [14:0] SLCB_OFS_INT_LOW_TRIGGER = 15'h0200;
  localparam logic [14:0] SLCB_OFS_REF_DIVIDER_CONTROLS = 15'h020e;
  localparam logic [14:0] SLCB_OFS_LOCK_DETECT_CONFIG = 15'h0214;
  localparam logic [14:0] SLCB_OFS_BAND_OVERRIDE_VALUE = 15'h0215;
  localparam logic [14:0] SLCB_OFS_CORE_OVERRIDE_VALUE = 15'h0217;
  localparam logic [14:0] SLCB_OFS_LOCK_WAIT_LIMIT = 15'h0218;
  localparam logic [14:0] SLCB_OFS_CAL_WAIT_LIMIT_LOW = 15'h021c;
  localparam logic [14:0] SLCB_OFS_CAL_WAIT_LIMIT_HIGH = 15'h021d;
  localparam logic [14:0] SLCB_OFS_AFC_INTERVAL_DIVISOR = 15'h021e;
  localparam logic [14:0] SLCB_OFS_CAL_INHIBIT = 15'h021f;
  localparam logic [14:0] SLCB_OFS_MODULATOR_CONTROL = 15'h022a;
  localparam logic [14:0] SLCB_OFS_PRESCALER_BIAS_CONTROL = 15'h022b;
  localparam logic [14:0] SLCB_OFS_PUMP_TRISTATE = 15'h022c;
  localparam logic [14:0] SLCB_OFS_PUMP_CONTROL = 15'h022d;
  localparam logic [14:0] SLCB_OFS_PUMP_CURRENT = 15'h022e;
  localparam logic [14:0] SLCB_OFS_BLEED_LEVEL = 15'h022f;
  localparam logic [14:0] SLCB_OFS_AUX_FRACTION_LOW = 15'h0233;
  localparam logic [14:0] SLCB_OFS_OVERRIDE_ENABLES = 15'h0240;
  localparam logic [14:0] SLCB_OFS_LOCK_READBACK = 15'h024d;

  // Storage slot of each stored register
  localparam int SLCB_IDX_REF_DIV = 0;
  localparam int SLCB_IDX_LOCK_CFG = 1;
  localparam int SLCB_IDX_BAND_VAL = 2;
  localparam int SLCB_IDX_CORE_VAL = 3;
  localparam int SLCB_IDX_LOCK_WAIT = 4;
  localparam int SLCB_IDX_CAL_WAIT_LO = 5;
  localparam int SLCB_IDX_CAL_WAIT_HI = 6;
  localparam int SLCB_IDX_AFC_DIV = 7;
  localparam int SLCB_IDX_CAL_INHIBIT = 8;
  localparam int SLCB_IDX_MOD_CTRL = 9;
  localparam int SLCB_IDX_PRESCALER = 10;
  localparam int SLCB_IDX_TRISTATE = 11;
  localparam int SLCB_IDX_PUMP_CTRL = 12;
  localparam int SLCB_IDX_PUMP_CURR = 13;
  localparam int SLCB_IDX_BLEED = 14;
  localparam int SLCB_IDX_AUX_FRAC = 15;

  // Tables in slot order, slot 0 rightmost
  localparam logic [SLCB_NREG-1:0][14:0] SLCB_REG_OFS = {
    SLCB_OFS_AUX_FRACTION_LOW, SLCB_OFS_BLEED_LEVEL, SLCB_OFS_PUMP_CURRENT,
    SLCB_OFS_PUMP_CONTROL, SLCB_OFS_PUMP_TRISTATE, SLCB_OFS_PRESCALER_BIAS_CONTROL,
    SLCB_OFS_MODULATOR_CONTROL, SLCB_OFS_CAL_INHIBIT, SLCB_OFS_AFC_INTERVAL_DIVISOR,
    SLCB_OFS_CAL_WAIT_LIMIT_HIGH, SLCB_OFS_CAL_WAIT_LIMIT_LOW, SLCB_OFS_LOCK_WAIT_LIMIT,
    SLCB_OFS_CORE_OVERRIDE_VALUE, SLCB_OFS_BAND_OVERRIDE_VALUE, SLCB_OFS_LOCK_DETECT_CONFIG,
    SLCB_OFS_REF_DIVIDER_CONTROLS};
  localparam logic [SLCB_NREG-1:0][7:0] SLCB_REG_RESET = {
    8'h00, 8'h08, 8'h0f, 8'h81, 8'h03, 8'h09, 8'h02, 8'h80,
    8'h14, 8'h00, 8'h20, 8'h1f, 8'h00, 8'h00, 8'h48, 8'h04};
  // Writable bits; the rest hold their reset value and are read-only
  localparam logic [SLCB_NREG-1:0][7:0] SLCB_REG_WMASK = {
    8'hff, 8'hff, 8'h0f, 8'he1, 8'h03, 8'h03, 8'hf0, 8'hff,
    8'hff, 8'h03, 8'hff, 8'h1f, 8'h0f, 8'hff, 8'hff, 8'h0d};

  localparam logic [7:0] SLCB_OVERRIDE_RESET = 8'h00;
  localparam logic [7:0] SLCB_OVERRIDE_WMASK = 8'h03;

  // Field positions
  localparam int SLCB_DOUBLER_BIT = 3;
  localparam int SLCB_HALVING_BIT = 0;
  localparam int SLCB_BIAS_LSB = 6;
  localparam int SLCB_PRECISION_LSB = 3;
  localparam int SLCB_INHIBIT_BIT = 6;
  localparam int SLCB_RUN_ZERO_BIT = 5;
  localparam int SLCB_RUN_OFF_BIT = 4;
  localparam int SLCB_POLARITY_BIT = 5;
  localparam int SLCB_BLEED_ON_BIT = 0;
  localparam int SLCB_BAND_ON_BIT = 0;
  localparam int SLCB_CORE_ON_BIT = 1;

  // Timing counts, in phase detector cycles
  localparam logic [13:0] SLCB_LOCK_BASE_CYCLES = 14'h0400;
  localparam logic [13:0] SLCB_LOCK_MAX_CYCLES = 14'h2000;
  localparam int SLCB_AFC_UNIT_SHIFT = 4;

  // Serial frame: one direction bit, fifteen address bits, eight data bits
  localparam logic [4:0] SLCB_HEAD_BITS = 5'h10;
  localparam logic [4:0] SLCB_FRAME_BITS = 5'h18;

  typedef enum logic [3:0] {
    SLCB_SPI_IDLE = 4'b0001,
    SLCB_SPI_HEAD = 4'b0010,
    SLCB_SPI_DATA = 4'b0100,
    SLCB_SPI_DONE = 4'b1000
  } slcb_spi_st_t;

endpackage : slcb_pkg

/* File: hdl/slcb_spi_port.sv */
// Serial port: four-wire frame decoder producing register writes and read data
module slcb_spi_port
  import slcb_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic spi_sclk,
  input wire logic spi_csb,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  output logic [14:0] bus_addr,
  output logic bus_wr,
  output logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata
);

  typedef struct packed {
    slcb_spi_st_t st;
    logic sclk_prev;
    logic [4:0] cnt;
    logic rd;
    logic [14:0] addr;
    logic [7:0] shin;
    logic [7:0] tx;
    logic wr;
  } slcb_spi_state_t;

  slcb_spi_state_t s_q;
  slcb_spi_state_t s_d;

  logic rise;
  logic fall;

  assign rise = spi_sclk & ~s_q.sclk_prev;
  assign fall = ~spi_sclk & s_q.sclk_prev;

  always_comb begin
    s_d = s_q;
    s_d.sclk_prev = spi_sclk;
    s_d.wr = 1'b0;
    case (s_q.st)
      SLCB_SPI_IDLE: begin
        s_d.cnt = 5'h00;
        if (!spi_csb) begin
          s_d.st = SLCB_SPI_HEAD;
        end
      end
      SLCB_SPI_HEAD: begin
        if (rise) begin
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == 5'h00) begin
            s_d.rd = spi_sdi;
          end else begin
            s_d.addr = {s_q.addr[13:0], spi_sdi};
          end
          if (s_q.cnt + 5'h01 == SLCB_HEAD_BITS) begin
            s_d.st = SLCB_SPI_DATA;
          end
        end
      end
      SLCB_SPI_DATA: begin
        // Address settled one cycle before, so the read mux is valid here
        if (s_q.cnt == SLCB_HEAD_BITS && !s_q.sclk_prev) begin
          s_d.tx = bus_rdata;
        end
        if (rise) begin
          s_d.cnt = s_q.cnt + 5'h01;
          s_d.shin = {s_q.shin[6:0], spi_sdi};
          if (s_q.cnt + 5'h01 == SLCB_FRAME_BITS) begin
            s_d.st = SLCB_SPI_DONE;
            s_d.wr = ~s_q.rd;
          end
        end else if (fall && s_q.cnt > SLCB_HEAD_BITS) begin
          s_d.tx = {s_q.tx[6:0], 1'b0};
        end
      end
      SLCB_SPI_DONE: begin
        // Extra clocks in one frame are ignored; no streaming
        s_d.cnt = s_q.cnt;
      end
      default: begin
        s_d.st = SLCB_SPI_IDLE;
      end
    endcase
    if (spi_csb) begin
      s_d.st = SLCB_SPI_IDLE;
      s_d.cnt = 5'h00;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '{st: SLCB_SPI_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_addr = s_q.addr;
  assign bus_wdata = s_q.shin;
  assign bus_wr = s_q.wr;
  assign spi_sdo = s_q.tx[7];
  assign spi_sdo_oe = s_q.rd & ~spi_csb & (s_q.st == SLCB_SPI_DATA);

endmodule : slcb_spi_port

/* File: hdl/slcb_synth_loop_config_bank.sv */
// Synthesizer loop configuration bank: registers, double buffering, lock detect, overrides
//
// Overview of operation
// R1 - Doubler enable bit 3, shadowed, applied at transfer
// R2 - Halving select shadowed: 1 divides reference by two
// R3 - Lock after 1024/2048/4096/8192 good detector cycles
// R4 - Band override value used only while enabled
// R5 - Core override value used only while enabled
// R6 - Software sets lock timeout near thirty microseconds
// R7 - Ten-bit calibration timeout split low/high registers
// R8 - Measurement lasts sixteen times interval divisor
// R9 - Software picks divisor for ten microsecond measurement
// R10 - Calibration disable bit 6 blocks calibration start
// R11 - Modulator run-at-zero and run-output-off controls
// R12 - Two-bit pump tristate decoded, mode 3 reset
// R13 - Polarity bit 5 swaps detector sense
// R14 - Bleed enable reset high, bleed level 0x8
// R15 - Pump current four bits, reset 0xF
// R16 - Auxiliary fraction low byte shadowed, applied at transfer
// R17 - Integer low byte write starts calibration
// R18 - Override enables at bits 0 and 1
// R19 - Lock state readable at bit 0
// R20 - All shadows copied together at integer low write
module slcb_synth_loop_config_bank
  import slcb_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic spi_sclk,
  input wire logic spi_csb,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic pfd_tick,
  input wire logic pfd_in_window,
  input wire logic pfd_up_raw,
  input wire logic pfd_dn_raw,
  input wire logic [7:0] cal_band_in,
  input wire logic [3:0] cal_core_in,
  input wire logic afc_meas_req,
  output logic ref_doubler_on,
  output logic ref_halving_select,
  output logic [1:0] lock_bias_current,
  output logic lock_detected,
  output logic [7:0] vco_band,
  output logic [3:0] vco_core,
  output logic [4:0] lock_wait_limit,
  output logic [9:0] cal_wait_limit,
  output logic [11:0] afc_meas_len,
  output logic afc_measuring,
  output logic afc_meas_done,
  output logic cal_inhibit,
  output logic cal_start,
  output logic modulator_run_zero_frac,
  output logic modulator_run_output_off,
  output logic [1:0] prescaler_bias,
  output logic [3:0] pump_tristate_mode,
  output logic pump_up,
  output logic pump_dn,
  output logic bleed_on,
  output logic [7:0] bleed_level,
  output logic [3:0] pump_current_level,
  output logic [7:0] aux_fraction_word_low
);

  typedef struct packed {
    logic [SLCB_NREG-1:0][7:0] regs;
    logic [7:0] override_en;
    logic act_doubler;
    logic act_halving;
    logic [7:0] act_aux;
    logic [13:0] lock_cnt;
    logic locked;
    logic cal_start;
    logic meas_run;
    logic [11:0] meas_cnt;
    logic meas_done;
    logic pump_up;
    logic pump_dn;
    logic [7:0] band;
    logic [3:0] core;
    logic [3:0] tri_mode;
  } slcb_bank_state_t;

  slcb_bank_state_t s_q;
  slcb_bank_state_t s_d;

  logic [14:0] bus_addr;
  logic bus_wr;
  logic [7:0] bus_wdata;
  logic [7:0] bus_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Serial port

  slcb_spi_port u_spi (
    .clock(clock),
    .sys_rst(sys_rst),
    .spi_sclk(spi_sclk),
    .spi_csb(spi_csb),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe),
    .bus_addr(bus_addr),
    .bus_wr(bus_wr),
    .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; shadows read back, not the active copies

  always_comb begin
    bus_rdata = 8'h00;
    for (int i = 0; i < SLCB_NREG; i++) begin
      if (bus_addr == SLCB_REG_OFS[i]) begin
        bus_rdata = s_q.regs[i];
      end
    end
    if (bus_addr == SLCB_OFS_OVERRIDE_ENABLES) begin
      bus_rdata = s_q.override_en;
    end
    if (bus_addr == SLCB_OFS_LOCK_READBACK) begin
      bus_rdata = {7'h00, s_q.locked}; // [R19]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic trigger_wr;
  logic [2:0] precision;
  logic [13:0] lock_target;
  logic [11:0] meas_len;
  logic polarity;

  always_comb begin
    s_d = s_q;
    trigger_wr = bus_wr && (bus_addr == SLCB_OFS_INT_LOW_TRIGGER);

    // Register writes, read-only bits keep their constant value
    for (int i = 0; i < SLCB_NREG; i++) begin
      if (bus_wr && bus_addr == SLCB_REG_OFS[i]) begin
        s_d.regs[i] = (bus_wdata & SLCB_REG_WMASK[i]) | (s_q.regs[i] & ~SLCB_REG_WMASK[i]);
      end
    end
    if (bus_wr && bus_addr == SLCB_OFS_OVERRIDE_ENABLES) begin
      s_d.override_en = bus_wdata & SLCB_OVERRIDE_WMASK; // [R18]
    end

    // Transfer takes the shadows as they stand before this write
    if (trigger_wr) begin
      s_d.act_doubler = s_q.regs[SLCB_IDX_REF_DIV][SLCB_DOUBLER_BIT]; // [R1] [R20]
      s_d.act_halving = s_q.regs[SLCB_IDX_REF_DIV][SLCB_HALVING_BIT]; // [R2] [R20]
      s_d.act_aux = s_q.regs[SLCB_IDX_AUX_FRAC]; // [R16] [R20]
    end

    // Calibration launch
    s_d.cal_start = trigger_wr && !s_q.regs[SLCB_IDX_CAL_INHIBIT][SLCB_INHIBIT_BIT]; // [R17] [R10]

    // Lock detect: consecutive good detector cycles
    precision = s_q.regs[SLCB_IDX_LOCK_CFG][SLCB_PRECISION_LSB +: 3];
    if (precision[2]) begin
      lock_target = SLCB_LOCK_MAX_CYCLES; // Undefined codes take the strictest count
    end else begin
      lock_target = SLCB_LOCK_BASE_CYCLES << precision[1:0]; // [R3]
    end
    if (pfd_tick) begin
      if (!pfd_in_window) begin
        s_d.lock_cnt = 14'h0000;
        s_d.locked = 1'b0;
      end else if (s_q.lock_cnt + 14'h0001 >= lock_target) begin
        s_d.lock_cnt = lock_target;
        s_d.locked = 1'b1; // [R3]
      end else begin
        s_d.lock_cnt = s_q.lock_cnt + 14'h0001;
      end
    end

    // Measurement window of sixteen detector cycles per divisor step
    meas_len = {s_q.regs[SLCB_IDX_AFC_DIV], 4'h0}; // [R8]
    s_d.meas_done = 1'b0;
    if (!s_q.meas_run) begin
      if (s_q.cal_start || (afc_meas_req && !s_q.regs[SLCB_IDX_CAL_INHIBIT][SLCB_INHIBIT_BIT])) begin
        s_d.meas_run = 1'b1; // [R10]
        s_d.meas_cnt = 12'h000;
      end
    end else if (pfd_tick) begin
      if (s_q.meas_cnt + 12'h001 >= meas_len) begin
        s_d.meas_run = 1'b0;
        s_d.meas_done = 1'b1; // [R8]
      end else begin
        s_d.meas_cnt = s_q.meas_cnt + 12'h001;
      end
    end
    // Disabling calibration aborts a running measurement
    if (s_q.regs[SLCB_IDX_CAL_INHIBIT][SLCB_INHIBIT_BIT]) begin
      s_d.meas_run = 1'b0; // [R10]
    end

    // Detector sense
    polarity = s_q.regs[SLCB_IDX_PUMP_CTRL][SLCB_POLARITY_BIT];
    s_d.pump_up = polarity ? pfd_dn_raw : pfd_up_raw; // [R13]
    s_d.pump_dn = polarity ? pfd_up_raw : pfd_dn_raw; // [R13]

    // Band and core selection
    s_d.band = s_q.override_en[SLCB_BAND_ON_BIT] ? s_q.regs[SLCB_IDX_BAND_VAL] : cal_band_in; // [R4]
    s_d.core = s_q.override_en[SLCB_CORE_ON_BIT] ?
      s_q.regs[SLCB_IDX_CORE_VAL][3:0] : cal_core_in; // [R5]

    // Tristate mode decode, one line per mode
    s_d.tri_mode = 4'h1 << s_q.regs[SLCB_IDX_TRISTATE][1:0]; // [R12]
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.regs <= SLCB_REG_RESET; // [R12] [R14] [R15] [R7]
      s_q.override_en <= SLCB_OVERRIDE_RESET;
      s_q.tri_mode <= 4'h8; // [R12]
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign ref_doubler_on = s_q.act_doubler; // [R1]
  assign ref_halving_select = s_q.act_halving; // [R2]
  assign lock_bias_current = s_q.regs[SLCB_IDX_LOCK_CFG][SLCB_BIAS_LSB +: 2];
  assign lock_detected = s_q.locked;
  assign vco_band = s_q.band;
  assign vco_core = s_q.core;
  assign lock_wait_limit = s_q.regs[SLCB_IDX_LOCK_WAIT][4:0];
  assign cal_wait_limit = {s_q.regs[SLCB_IDX_CAL_WAIT_HI][1:0],
    s_q.regs[SLCB_IDX_CAL_WAIT_LO]}; // [R7]
  assign afc_meas_len = {s_q.regs[SLCB_IDX_AFC_DIV], 4'h0}; // [R8]
  assign afc_measuring = s_q.meas_run;
  assign afc_meas_done = s_q.meas_done;
  assign cal_inhibit = s_q.regs[SLCB_IDX_CAL_INHIBIT][SLCB_INHIBIT_BIT]; // [R10]
  assign cal_start = s_q.cal_start;
  assign modulator_run_zero_frac = s_q.regs[SLCB_IDX_MOD_CTRL][SLCB_RUN_ZERO_BIT]; // [R11]
  assign modulator_run_output_off = s_q.regs[SLCB_IDX_MOD_CTRL][SLCB_RUN_OFF_BIT]; // [R11]
  assign prescaler_bias = s_q.regs[SLCB_IDX_PRESCALER][1:0];
  assign pump_tristate_mode = s_q.tri_mode;
  assign pump_up = s_q.pump_up;
  assign pump_dn = s_q.pump_dn;
  assign bleed_on = s_q.regs[SLCB_IDX_PUMP_CTRL][SLCB_BLEED_ON_BIT]; // [R14]
  assign bleed_level = s_q.regs[SLCB_IDX_BLEED]; // [R14]
  assign pump_current_level = s_q.regs[SLCB_IDX_PUMP_CURR][3:0]; // [R15]
  assign aux_fraction_word_low = s_q.act_aux; // [R16]

endmodule : slcb_synth_loop_config_bank

/* File: verification/slcb_asserts.sv */
// Checker: port-level timing relations of the synth loop bank
module slcb_asserts
  import slcb_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic spi_csb,
  input wire logic spi_sdo_oe,
  input wire logic pfd_tick,
  input wire logic pfd_in_window,
  input wire logic pfd_up_raw,
  input wire logic pfd_dn_raw,
  input wire logic lock_detected,
  input wire logic [11:0] afc_meas_len,
  input wire logic afc_measuring,
  input wire logic afc_meas_done,
  input wire logic cal_inhibit,
  input wire logic cal_start,
  input wire logic [3:0] pump_tristate_mode,
  input wire logic pump_up,
  input wire logic pump_dn
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // Good ticks since the last bad one; saturates so it never wraps to zero
  logic [14:0] good_q;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      good_q <= 15'h0000;
    end else if (pfd_tick) begin
      good_q <= !pfd_in_window ? 15'h0000 : good_q + {14'h0000, good_q != 15'h7fff};
    end
  end
  // Ticks counted inside the running measurement; cleared whenever it is idle
  logic [11:0] meas_ticks_q;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meas_ticks_q <= 12'h000;
    end else if (!afc_measuring) begin
      meas_ticks_q <= 12'h000;
    end else if (pfd_tick) begin
      meas_ticks_q <= meas_ticks_q + 12'h001;
    end
  end
  sequence s_start;
    cal_start;
  endsequence
  sequence s_run;
    ##[1:2] afc_measuring;
  endsequence
  sequence s_bad_tick;
    pfd_tick && !pfd_in_window;
  endsequence
  ////////////////////////////////////////
  a_len_scaled: assert property (afc_meas_len[3:0] == 4'h0)
    else $error("measurement length not a multiple of 16");
  a_meas_length: assert property (afc_meas_done && afc_meas_len != 12'h000 |->
    meas_ticks_q == afc_meas_len)
    else $error("measurement length differs from sixteen times divisor");
  a_meas_follows: assert property (s_start |-> s_run)
    else $error("measurement did not start after calibration start");
  a_done_pulse: assert property (afc_meas_done |=> !afc_meas_done ##0 !afc_measuring)
    else $error("measurement done not a single pulse");
  a_start_pulse: assert property (cal_start |=> !cal_start)
    else $error("calibration start longer than one cycle");
  a_inhibit_blocks: assert property (cal_inhibit && $past(cal_inhibit) |-> !cal_start)
    else $error("calibration started while inhibited");
  a_lock_min: assert property ($rose(lock_detected) |-> good_q >= 15'h0400)
    else $error("lock declared too early");
  a_lock_drop: assert property (s_bad_tick |-> ##[1:2] !lock_detected)
    else $error("lock kept after an out of window tick");
  a_tristate_hot: assert property ($onehot(pump_tristate_mode))
    else $error("tristate mode not one-hot");
  a_pump_sense: assert property (!$past(sys_rst) |->
    (pump_up == $past(pfd_up_raw) && pump_dn == $past(pfd_dn_raw)) ||
    (pump_up == $past(pfd_dn_raw) && pump_dn == $past(pfd_up_raw)))
    else $error("pump outputs not the detector pair");
  a_sdo_quiet: assert property (spi_csb |-> !spi_sdo_oe)
    else $error("serial output driven while deselected");
endmodule : slcb_asserts

bind slcb_synth_loop_config_bank slcb_asserts i_asserts (.clock, .sys_rst, .spi_csb,
  .spi_sdo_oe, .pfd_tick, .pfd_in_window, .pfd_up_raw, .pfd_dn_raw, .lock_detected,
  .afc_meas_len, .afc_measuring, .afc_meas_done, .cal_inhibit, .cal_start,
  .pump_tristate_mode, .pump_up, .pump_dn);

/* File: verification/testbench.sv */
// Testbench: serial register access and port checks of the synth loop bank
module testbench
  import slcb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, sys_rst = 1'b1, spi_sclk = 1'b0, spi_csb = 1'b1, spi_sdi = 1'b0;
  logic pfd_tick = 1'b0, pfd_in_window = 1'b0, pfd_up_raw = 1'b0, pfd_dn_raw = 1'b0;
  logic [7:0] cal_band_in = 8'h00;
  logic [3:0] cal_core_in = 4'h0;
  logic afc_meas_req = 1'b0;
  logic spi_sdo, spi_sdo_oe, ref_doubler_on, ref_halving_select, lock_detected, afc_measuring;
  logic afc_meas_done, cal_inhibit, cal_start, modulator_run_zero_frac, modulator_run_output_off;
  logic pump_up, pump_dn, bleed_on;
  logic [1:0] lock_bias_current, prescaler_bias;
  logic [7:0] vco_band, bleed_level, aux_fraction_word_low;
  logic [3:0] vco_core, pump_tristate_mode, pump_current_level;
  logic [4:0] lock_wait_limit;
  logic [9:0] cal_wait_limit;
  logic [11:0] afc_meas_len;
  int failures = 0, num_checks = 0, cyc = 0, starts = 0, dones = 0;

  slcb_synth_loop_config_bank i_dut (.clock, .sys_rst, .spi_sclk, .spi_csb, .spi_sdi,
    .spi_sdo, .spi_sdo_oe, .pfd_tick, .pfd_in_window, .pfd_up_raw, .pfd_dn_raw,
    .cal_band_in, .cal_core_in, .afc_meas_req, .ref_doubler_on, .ref_halving_select,
    .lock_bias_current, .lock_detected, .vco_band, .vco_core, .lock_wait_limit,
    .cal_wait_limit, .afc_meas_len, .afc_measuring, .afc_meas_done, .cal_inhibit,
    .cal_start, .modulator_run_zero_frac, .modulator_run_output_off, .prescaler_bias,
    .pump_tristate_mode, .pump_up, .pump_dn, .bleed_on, .bleed_level,
    .pump_current_level, .aux_fraction_word_low);

  always #2 clock = ~clock;
  ////////////////////////////////////////
  // Whole run needs about 14k cycles
  always @(posedge clock) begin
    cyc++;
    if (cal_start === 1'b1) starts++;
    if (afc_meas_done === 1'b1) dones++;
    if (cyc == 40000) begin
      failures++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Sclk levels of 3 clocks keep above the sampler's two-clock minimum
  task automatic frame(input logic rd, input logic [14:0] a, input logic [7:0] d,
                       output logic [7:0] q);
    logic [23:0] f;
    f = {rd, a, d};
    q = 8'h00;
    spi_csb = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_sdi = f[i];
      repeat (3) @(negedge clock);
      if (i < 8) q[i] = spi_sdo;
      spi_sclk = 1'b1;
      repeat (3) @(negedge clock);
      spi_sclk = 1'b0;
    end
    repeat (3) @(negedge clock);
    spi_csb = 1'b1;
    repeat (3) @(negedge clock);
  endtask : frame

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] q;
    frame(1'b0, a, d, q);
  endtask : wr

  task automatic rd(input logic [14:0] a, input logic [7:0] exp);
    logic [7:0] q;
    frame(1'b1, a, 8'h00, q);
    chk(q, exp, "read");
  endtask : rd

  task automatic tick(input int n, input logic win);
    pfd_in_window = win;
    repeat (n) begin
      pfd_tick = 1'b1;
      @(negedge clock);
      pfd_tick = 1'b0;
      @(negedge clock);
    end
    @(negedge clock);
  endtask : tick
  ////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < SLCB_NREG; i++) begin
      rd(SLCB_REG_OFS[i], SLCB_REG_RESET[i]);
    end
    rd(SLCB_OFS_OVERRIDE_ENABLES, 8'h00);
    rd(15'h0216, 8'h00);
    chk(pump_tristate_mode, 4'h8, "tristate");
    chk({lock_bias_current, lock_wait_limit, prescaler_bias}, 9'h0fd, "fields");
    chk({bleed_on, bleed_level, pump_current_level}, 13'h108f, "pump");
    chk(cal_wait_limit, 10'h020, "cal wait");
    chk(afc_meas_len, 12'h140, "meas len");
  endtask : t_reset

  task automatic t_buffer();
    int s;
    s = starts;
    wr(SLCB_OFS_REF_DIVIDER_CONTROLS, 8'h09);
    wr(SLCB_OFS_AUX_FRACTION_LOW, 8'ha5);
    chk({ref_doubler_on, ref_halving_select, aux_fraction_word_low}, 10'h000, "early");
    rd(SLCB_OFS_REF_DIVIDER_CONTROLS, 8'h09);
    wr(SLCB_OFS_INT_LOW_TRIGGER, 8'h00);
    chk({ref_doubler_on, ref_halving_select, aux_fraction_word_low}, 10'h3a5, "moved");
    chk(starts - s, 1, "start");
    wr(SLCB_OFS_CAL_INHIBIT, 8'hc0);
    chk(cal_inhibit, 1'b1, "inhibit");
    s = starts;
    wr(SLCB_OFS_REF_DIVIDER_CONTROLS, 8'h08);
    wr(SLCB_OFS_INT_LOW_TRIGGER, 8'h00);
    chk(starts - s, 0, "blocked");
    chk({ref_doubler_on, ref_halving_select}, 2'b10, "undivided");
    wr(SLCB_OFS_CAL_INHIBIT, 8'h80);
  endtask : t_buffer

  task automatic t_meas();
    int d;
    wr(SLCB_OFS_AFC_INTERVAL_DIVISOR, 8'h02);
    chk(afc_meas_len, 12'h020, "len");
    d = dones;
    wr(SLCB_OFS_INT_LOW_TRIGGER, 8'h00);
    chk(afc_measuring, 1'b1, "run");
    tick(31, 1'b0);
    chk(afc_measuring, 1'b1, "still");
    tick(1, 1'b0);
    chk({afc_measuring, 8'(dones - d)}, 9'h001, "done");
    afc_meas_req = 1'b1;
    @(negedge clock);
    afc_meas_req = 1'b0;
    repeat (2) @(negedge clock);
    chk(afc_measuring, 1'b1, "again");
    wr(SLCB_OFS_CAL_INHIBIT, 8'hc0);
    chk(afc_measuring, 1'b0, "abort");
    wr(SLCB_OFS_CAL_INHIBIT, 8'h80);
  endtask : t_meas

  task automatic t_lock();
    wr(SLCB_OFS_LOCK_DETECT_CONFIG, 8'h40);
    tick(1, 1'b0);
    tick(1023, 1'b1);
    chk(lock_detected, 1'b0, "early lock");
    tick(1, 1'b1);
    chk(lock_detected, 1'b1, "lock");
    rd(SLCB_OFS_LOCK_READBACK, 8'h01);
    tick(1, 1'b0);
    chk(lock_detected, 1'b0, "unlock");
    wr(SLCB_OFS_LOCK_DETECT_CONFIG, 8'h88);
    chk(lock_bias_current, 2'b10, "bias");
    tick(2047, 1'b1);
    chk(lock_detected, 1'b0, "early lock 2k");
    tick(1, 1'b1);
    chk(lock_detected, 1'b1, "lock 2k");
  endtask : t_lock

  task automatic t_override();
    cal_band_in = 8'h3c;
    cal_core_in = 4'h6;
    wr(SLCB_OFS_BAND_OVERRIDE_VALUE, 8'ha7);
    wr(SLCB_OFS_CORE_OVERRIDE_VALUE, 8'h09);
    chk({vco_band, vco_core}, 12'h3c6, "cal pick");
    wr(SLCB_OFS_OVERRIDE_ENABLES, 8'h01);
    chk({vco_band, vco_core}, 12'ha76, "band");
    wr(SLCB_OFS_OVERRIDE_ENABLES, 8'h02);
    chk({vco_band, vco_core}, 12'h3c9, "core");
  endtask : t_override

  task automatic t_pump();
    for (int m = 0; m < 4; m++) begin
      wr(SLCB_OFS_PUMP_TRISTATE, 8'(m));
      chk(pump_tristate_mode, 4'h1 << m, "mode");
    end
    wr(SLCB_OFS_PUMP_CURRENT, 8'hf5);
    rd(SLCB_OFS_PUMP_CURRENT, 8'h05);
    wr(SLCB_OFS_BLEED_LEVEL, 8'h80);
    wr(SLCB_OFS_PUMP_CONTROL, 8'h20);
    chk({bleed_on, bleed_level, pump_current_level}, 13'h0805, "bleed");
    pfd_up_raw = 1'b1;
    repeat (3) @(negedge clock);
    chk({pump_up, pump_dn}, 2'b01, "swapped");
    wr(SLCB_OFS_PUMP_CONTROL, 8'h01);
    chk({pump_up, pump_dn}, 2'b10, "direct");
    pfd_up_raw = 1'b0;
    wr(SLCB_OFS_MODULATOR_CONTROL, 8'hff);
    chk({modulator_run_zero_frac, modulator_run_output_off}, 2'b11, "mod");
    rd(SLCB_OFS_MODULATOR_CONTROL, 8'hf2);
    wr(SLCB_OFS_CAL_WAIT_LIMIT_LOW, 8'h55);
    wr(SLCB_OFS_CAL_WAIT_LIMIT_HIGH, 8'hff);
    chk(cal_wait_limit, 10'h355, "cal wait");
    rd(SLCB_OFS_CAL_WAIT_LIMIT_HIGH, 8'h03);
    wr(SLCB_OFS_LOCK_WAIT_LIMIT, 8'hea);
    chk(lock_wait_limit, 5'h0a, "lock wait");
  endtask : t_pump
  ////////////////////////////////////////
  initial begin
    repeat (5) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    t_reset();
    t_buffer();
    t_meas();
    t_lock();
    t_override();
    t_pump();
    finish_test();
  end
endmodule : testbench
